/* hw/ftf_host.sv */
`default_nettype none
// host controller for the fall-through fifo: drives shift-in, shift-out,
// master clear and output enable; one strobe at a time, so the fifo's
// own independence of load and unload is not exploited here
module ftf_host
(
   // clock and reset
   input wire logic clock,
   input wire logic nrst,
   input wire logic clk_en,
   // user write side
   input wire logic wr_valid,
   input wire logic [ftf_pkg::word_w-1:0] wr_data,
   output logic wr_ready,
   // user read side
   input wire logic rd_req,
   output logic rd_valid,
   output logic [ftf_pkg::word_w-1:0] rd_data,
   // user clear request
   input wire logic clear_req,
   // fifo pins
   output logic master_clear_n,
   output logic shift_in,
   output logic shift_out,
   output logic output_enable_n,
   output logic [ftf_pkg::word_w-1:0] word_in,
   input wire logic input_ready_flag,
   input wire logic output_ready_flag,
   input wire logic [ftf_pkg::word_w-1:0] word_out
);
   ftf_sync_if sy ();
   ftf_sync u_sync
   (
      .clock(clock),
      .nrst(nrst),
      .clk_en(clk_en),
      .pin_in_ready(input_ready_flag),
      .pin_out_ready(output_ready_flag),
      .pin_word(word_out),
      .sync(sy.src)
   );
   // =========================================
   // sequencer
   ftf_pkg::ftf_state_t state;
   ftf_pkg::ftf_state_t next_state;
   logic [ftf_pkg::cnt_w-1:0] cnt;
   logic [ftf_pkg::cnt_w-1:0] next_cnt;
   logic next_master_clear_n;
   logic next_shift_in;
   logic next_shift_out;
   logic next_output_enable_n;
   logic [ftf_pkg::word_w-1:0] next_word_in;
   logic next_wr_ready;
   logic next_rd_valid;
   logic [ftf_pkg::word_w-1:0] next_rd_data;
   function automatic logic [ftf_pkg::cnt_w-1:0] load_cnt(input int unsigned cyc);
      load_cnt = ftf_pkg::cnt_w'(cyc);
   endfunction : load_cnt
   always_comb
   begin
      next_state = state;
      next_cnt = (cnt != ftf_pkg::cnt_zero) ? cnt - ftf_pkg::cnt_one : cnt;
      next_master_clear_n = master_clear_n;
      next_shift_in = shift_in;
      next_shift_out = shift_out;
      next_output_enable_n = output_enable_n;
      next_word_in = word_in;
      next_wr_ready = 1'b0;
      next_rd_valid = 1'b0;
      next_rd_data = rd_data;
      unique case (state)
         ftf_pkg::st_clear:
         begin
            // clear overrides any strobe while held
            next_shift_in = 1'b0;
            next_shift_out = 1'b0;
            if (cnt == ftf_pkg::cnt_zero)
            begin
               next_master_clear_n = 1'b1;
               next_cnt = load_cnt(ftf_pkg::pulse_cyc);
               next_state = ftf_pkg::st_low;
            end
         end
         ftf_pkg::st_idle:
         begin
            if (clear_req)
            begin
               next_master_clear_n = 1'b0;
               next_cnt = load_cnt(ftf_pkg::clear_cyc);
               next_state = ftf_pkg::st_clear;
            end
            else if (rd_req && sy.out_ready)
            begin
               // take the word before the strobe; output stage may change after
               next_rd_data = sy.word;
               next_rd_valid = 1'b1;
               next_output_enable_n = 1'b1;
               next_shift_out = 1'b1;
               next_cnt = load_cnt(ftf_pkg::pulse_cyc);
               next_state = ftf_pkg::st_out_high;
            end
            else if (wr_valid && sy.in_ready)
            begin
               next_word_in = wr_data;
               next_shift_in = 1'b1;
               next_wr_ready = 1'b1;
               next_cnt = load_cnt(ftf_pkg::pulse_cyc);
               next_state = ftf_pkg::st_in_high;
            end
         end
         ftf_pkg::st_in_high:
         begin
            // hold shift-in until the fifo shows busy, then release it
            if (cnt == ftf_pkg::cnt_zero && !sy.in_ready)
            begin
               next_shift_in = 1'b0;
               next_cnt = load_cnt(ftf_pkg::pulse_cyc);
               next_state = ftf_pkg::st_low;
            end
         end
         ftf_pkg::st_out_high:
         begin
            if (cnt == ftf_pkg::cnt_zero && !sy.out_ready)
            begin
               next_shift_out = 1'b0;
               next_output_enable_n = 1'b0;
               next_cnt = load_cnt(ftf_pkg::pulse_cyc);
               next_state = ftf_pkg::st_low;
            end
         end
         ftf_pkg::st_low:
         begin
            // low time of pulse_cyc only; the flag was already seen busy through the synchroniser
            if (cnt == ftf_pkg::cnt_zero)
            begin
               next_output_enable_n = 1'b0;
               next_state = ftf_pkg::st_idle;
            end
         end
         default:
         begin
            next_state = ftf_pkg::st_idle;
         end
      endcase
      if (!clk_en)
      begin
         next_state = state;
         next_cnt = cnt;
         next_master_clear_n = master_clear_n;
         next_shift_in = shift_in;
         next_shift_out = shift_out;
         next_output_enable_n = output_enable_n;
         next_word_in = word_in;
         next_wr_ready = wr_ready;
         next_rd_valid = rd_valid;
         next_rd_data = rd_data;
      end
   end
   // power-up starts with a master clear pulse
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         state <= ftf_pkg::st_clear;
         cnt <= ftf_pkg::cnt_w'(ftf_pkg::clear_cyc);
         master_clear_n <= 1'b0;
         shift_in <= 1'b0;
         shift_out <= 1'b0;
         output_enable_n <= 1'b0;
         word_in <= '0;
         wr_ready <= 1'b0;
         rd_valid <= 1'b0;
         rd_data <= '0;
      end
      else
      begin
         state <= next_state;
         cnt <= next_cnt;
         master_clear_n <= next_master_clear_n;
         shift_in <= next_shift_in;
         shift_out <= next_shift_out;
         output_enable_n <= next_output_enable_n;
         word_in <= next_word_in;
         wr_ready <= next_wr_ready;
         rd_valid <= next_rd_valid;
         rd_data <= next_rd_data;
      end
   end
endmodule : ftf_host
`default_nettype wire

/* hw/ftf_pkg.sv */
// Overview of operation
// - after power-up the host pulses master clear low once to clear the fifo.
// - the host raises shift-in only while input-ready is high; word_in is captured.
// - the host returns shift-in low after each load before the next one.
// - the host raises shift-out only while output-ready is high; output-ready then falls.
`default_nettype none
package ftf_pkg;
   localparam int unsigned word_w = 9;
   localparam int unsigned depth = 64;
   localparam int unsigned clk_ns = 50;
   // =========================================
   // strobe and clear timing, ns
   localparam int unsigned clear_ns = 100;
   localparam int unsigned pulse_ns = 50;
   localparam int unsigned clear_cyc = (clear_ns + clk_ns - 1) / clk_ns;
   localparam int unsigned pulse_cyc = (pulse_ns + clk_ns - 1) / clk_ns;
   localparam int unsigned cnt_w = 4;
   localparam logic [cnt_w-1:0] cnt_zero = 4'h0;
   localparam logic [cnt_w-1:0] cnt_one = 4'h1;
   // =========================================
   // sequencer states
   typedef enum logic [4:0]
   {
      st_clear = 5'h01,
      st_idle = 5'h02,
      st_in_high = 5'h04,
      st_out_high = 5'h08,
      st_low = 5'h10
   } ftf_state_t;
endpackage : ftf_pkg
`default_nettype wire

/* hw/ftf_sync.sv */
`default_nettype none
// two-stage synchroniser for flags and data coming back from the fifo pins
module ftf_sync
(
   // clock and reset
   input wire logic clock,
   input wire logic nrst,
   input wire logic clk_en,
   // raw pins
   input wire logic pin_in_ready,
   input wire logic pin_out_ready,
   input wire logic [ftf_pkg::word_w-1:0] pin_word,
   // synchronised
   ftf_sync_if.src sync
);
   logic [ftf_pkg::word_w+1:0] meta;
   logic [ftf_pkg::word_w+1:0] next_meta;
   logic [ftf_pkg::word_w+1:0] stable;
   logic [ftf_pkg::word_w+1:0] next_stable;
   always_comb
   begin
      next_meta = clk_en ? {pin_in_ready, pin_out_ready, pin_word} : meta;
      next_stable = clk_en ? meta : stable;
   end
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         meta <= '0;
         stable <= '0;
      end
      else
      begin
         meta <= next_meta;
         stable <= next_stable;
      end
   end
   assign sync.in_ready = stable[ftf_pkg::word_w+1];
   assign sync.out_ready = stable[ftf_pkg::word_w];
   assign sync.word = stable[ftf_pkg::word_w-1:0];
endmodule : ftf_sync
`default_nettype wire

/* hw/ftf_sync_if.sv */
`default_nettype none
interface ftf_sync_if;
   logic in_ready;
   logic out_ready;
   logic [ftf_pkg::word_w-1:0] word;
   modport src (output in_ready, output out_ready, output word);
   modport dst (input in_ready, input out_ready, input word);
endinterface : ftf_sync_if
`default_nettype wire

/* sim/ftf_fifo_model.sv */
`default_nettype none
// =========
// behavioural fifo, fall-through modelled as a 10 ns sweep
module ftf_fifo_model
(
   // control pins
   input wire logic master_clear_n,
   input wire logic shift_in,
   input wire logic shift_out,
   input wire logic output_enable_n,
   // data and flags
   input wire logic [8:0] word_in,
   output logic input_ready_flag,
   output logic output_ready_flag,
   output logic [8:0] word_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [8:0] mem[$];
   logic [8:0] stage = 9'h1a5;
   logic [8:0] hold;
   bit in_busy = 0;
   // a floating bus would read as junk, so show the inverse
   assign word_out = output_enable_n ? ~stage : stage;
   always #10
      if (!master_clear_n)
      begin
         mem.delete();
         output_ready_flag = 1'h0;
         input_ready_flag = 1'h1;
      end
      else
      begin
         // the output stage only counts as free once shift-out has fallen
         if (!in_busy)
            input_ready_flag = mem.size() + int'(output_ready_flag | shift_out) < 64;
         if (!output_ready_flag && !shift_out && mem.size() > 0)
         begin
            stage = mem.pop_front();
            output_ready_flag = 1'h1;
         end
      end
   // a strobe held on a full fifo waits for the freed slot to bubble up
   always @(posedge shift_in)
   begin
      wait (!shift_in || (master_clear_n && input_ready_flag));
      if (shift_in)
      begin
         in_busy = 1;
         // word_in moves on the same edge as the strobe, so look just after it
         #1 hold = word_in;
         #19 input_ready_flag = 1'h0;
         @(negedge shift_in);
         mem.push_back(hold);
         #30 in_busy = 0;
      end
   end
   always @(posedge shift_out)
      if (output_ready_flag)
         #20 output_ready_flag = 1'h0;
endmodule : ftf_fifo_model
`default_nettype wire

/* sim/ftf_host_checker.sv */
`default_nettype none
// =========
// pin protocol of the host
module ftf_host_checker
(
   // clock and user side
   input wire logic clock,
   input wire logic nrst,
   input wire logic clk_en,
   input wire logic wr_valid,
   input wire logic [8:0] wr_data,
   input wire logic wr_ready,
   input wire logic rd_req,
   input wire logic rd_valid,
   input wire logic [8:0] rd_data,
   input wire logic clear_req,
   // fifo pins
   input wire logic master_clear_n,
   input wire logic shift_in,
   input wire logic shift_out,
   input wire logic output_enable_n,
   input wire logic [8:0] word_in,
   input wire logic input_ready_flag,
   input wire logic output_ready_flag,
   input wire logic [8:0] word_out
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);
   // flags pass two sync stages, hence depth 3
   a_si_ready: assert property ($rose(shift_in) |-> $past(input_ready_flag, 3))
      else $error("shift-in without ready");
   a_so_ready: assert property ($rose(shift_out) |-> $past(output_ready_flag, 3))
      else $error("shift-out without ready");
   a_si_gap: assert property ($fell(shift_in) |-> !shift_in [*2])
      else $error("shift-in gap short");
   a_si_hold: assert property ($rose(shift_in) |-> shift_in [*2])
      else $error("shift-in pulse short");
   a_word_hold: assert property (shift_in && $past(shift_in) |-> $stable(word_in))
      else $error("word moved under strobe");
   a_wr_take: assert property (wr_ready |-> $rose(shift_in) ##1 !wr_ready)
      else $error("write take mismatch");
   a_rd_take: assert property (rd_valid |-> $rose(shift_out) && output_enable_n)
      else $error("read take mismatch");
   a_clear_quiet: assert property (!master_clear_n |-> !shift_in && !shift_out)
      else $error("strobe during clear");
   a_clear_len: assert property ($fell(master_clear_n) |-> !master_clear_n [*3])
      else $error("clear pulse short");
endmodule : ftf_host_checker
bind ftf_host ftf_host_checker chk (.*);
`default_nettype wire

/* sim/testbench.sv */
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 1'h0, nrst = 1'h0, clk_en = 1'h1, wr_valid = 1'h0, rd_req = 1'h0;
   logic clear_req = 1'h0;
   logic [8:0] wr_data = 9'h000;
   logic wr_ready, rd_valid, master_clear_n, shift_in, shift_out, output_enable_n;
   logic input_ready_flag, output_ready_flag;
   logic [8:0] rd_data, word_in, word_out;
   int err_count = 0, total_checks = 0;
   bit got;
   ftf_host dut (.*);
   ftf_fifo_model fifo (.*);
   always #25 clock = ~clock;
   // =========
   // shared tasks
   task automatic check(input bit ok, input string m);
      total_checks++;
      if (!ok)
      begin
         err_count++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask : check
   task automatic put(input logic [8:0] d, input int lim, output bit ok);
      int n;
      @(negedge clock);
      wr_data = d;
      wr_valid = 1'h1;
      for (n = 0; n < lim && wr_ready !== 1'h1; n++)
         @(negedge clock);
      wr_valid = 1'h0;
      ok = n < lim;
   endtask : put
   task automatic get(input logic [8:0] e, input int lim, input bit want);
      int n;
      @(negedge clock);
      rd_req = 1'h1;
      for (n = 0; n < lim && rd_valid !== 1'h1; n++)
         @(negedge clock);
      rd_req = 1'h0;
      check((n < lim) == want, "read handshake");
      if (want)
         check(rd_data === e, "read data");
   endtask : get
   task automatic complete_run;
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : complete_run
   // =========
   // scenarios
   task automatic t_order;
      put(9'h1ff, 200, got);
      put(9'h000, 200, got);
      put(9'h155, 200, got);
      get(9'h1ff, 200, 1);
      get(9'h000, 200, 1);
      get(9'h155, 200, 1);
   endtask : t_order
   task automatic t_full;
      for (int i = 0; i < 64; i++)
         put(9'(i * 5 + 3), 200, got);
      put(9'h0aa, 40, got);
      check(!got, "write into full fifo");
      get(9'h003, 200, 1);
      put(9'h0aa, 200, got);
      check(got, "write after space freed");
      for (int i = 1; i < 64; i++)
         get(9'(i * 5 + 3), 200, 1);
      get(9'h0aa, 200, 1);
      get(9'h000, 40, 0);
   endtask : t_full
   task automatic t_clear;
      int n;
      put(9'h0f0, 200, got);
      @(negedge clock);
      clear_req = 1'h1;
      for (n = 0; n < 50 && master_clear_n !== 1'h0; n++)
         @(negedge clock);
      clear_req = 1'h0;
      check(n < 50, "clear not issued");
      repeat (20) @(negedge clock);
      get(9'h000, 40, 0);
      put(9'h10f, 200, got);
      get(9'h10f, 200, 1);
   endtask : t_clear
   task automatic t_freeze;
      int n;
      @(negedge clock);
      clk_en = 1'h0;
      wr_data = 9'h0c3;
      wr_valid = 1'h1;
      for (n = 0; n < 10 && wr_ready !== 1'h1 && shift_in !== 1'h1; n++)
         @(negedge clock);
      check(n == 10, "moved while clock enable low");
      clk_en = 1'h1;
      for (n = 0; n < 200 && wr_ready !== 1'h1; n++)
         @(negedge clock);
      wr_valid = 1'h0;
      check(n < 200, "write after clock enable");
      get(9'h0c3, 200, 1);
   endtask : t_freeze
   task automatic t_reset;
      put(9'h03c, 200, got);
      check(got, "load before reset");
      repeat (10) @(negedge clock);
      nrst = 1'h0;
      repeat (3) @(negedge clock);
      check(master_clear_n === 1'h0 && shift_in === 1'h0, "held in reset");
      nrst = 1'h1;
      repeat (20) @(negedge clock);
      check(master_clear_n === 1'h1 && rd_valid === 1'h0, "clear after reset");
      get(9'h03c, 40, 0);
   endtask : t_reset
   initial
   begin
      repeat (10) @(negedge clock);
      nrst = 1'h1;
      repeat (20) @(negedge clock);
      check(master_clear_n === 1'h1 && rd_valid === 1'h0, "after reset");
      t_order();
      t_full();
      t_clear();
      t_freeze();
      t_reset();
      complete_run();
   end
   // whole run needs well under 100 us
   initial
   begin
      #500us;
      err_count++;
      complete_run();
   end
endmodule : testbench
`default_nettype wire
